// [hw/chg_pkg.sv]
// Constants, types and register map of the charger serial slave
package chg_pkg;

  // ==========================================================
  // Link addressing
  // ==========================================================
  localparam logic [6:0] DEV_ADDR = 7'h6A;
  localparam logic [4:0] HS_CODE  = 5'h01;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // ==========================================================
  // Register offsets
  // ==========================================================
  localparam logic [7:0] ADR_STATUS = 8'h00;
  localparam logic [7:0] ADR_CHARGE = 8'h01;
  localparam logic [7:0] ADR_FLOAT  = 8'h02;
  localparam logic [7:0] ADR_ID     = 8'h03;
  localparam logic [7:0] ADR_CURR   = 8'h04;
  localparam logic [7:0] ADR_WEAK   = 8'h05;
  localparam logic [7:0] ADR_RCH    = 8'h07;
  localparam logic [7:0] ADR_MON    = 8'h10;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [1:0] RST_STATUS_RW = 2'h1;
  localparam logic [7:0] RST_CHARGE    = 8'h70;
  localparam logic [7:0] RST_FLOAT     = 8'h0A;
  localparam logic [7:0] RST_CURR      = 8'h00;
  localparam logic [2:0] RST_WEAK_HI   = 3'h3;
  localparam logic [2:0] RST_WEAK_VSP  = 3'h4;
  localparam logic [7:0] RST_RCH       = 8'h01;
  localparam logic [7:0] RD_UNMAPPED   = 8'h00;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int BIT_STAT_EN = 6;
  localparam int BIT_TERM_EN = 3;
  localparam int BIT_CHG_DIS = 2;
  localparam int BIT_HIZ     = 1;
  localparam int BIT_BST_REQ = 0;
  localparam int BIT_PIN_POL = 1;
  localparam int BIT_PIN_EN  = 0;

  // ==========================================================
  // Fault and charge-state codes
  // ==========================================================
  localparam logic [2:0] FLT_NONE  = 3'h0;
  localparam logic [2:0] FLT_OVP   = 3'h1;
  localparam logic [2:0] FLT_BOOST = 3'h2;
  localparam logic [2:0] FLT_HOT   = 3'h5;
  localparam logic [1:0] CS_CHARGING = 2'h1;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLK_MHZ      = 200;
  localparam int ILIM_TIME_NS = 50_000;
  localparam int ILIM_CYC     = (ILIM_TIME_NS * CLK_MHZ + 999) / 1000;

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_DEV   = 3'b001,
    ST_REG   = 3'b010,
    ST_WR    = 3'b011,
    ST_ACK   = 3'b100,
    ST_TX    = 3'b101,
    ST_TXACK = 3'b110,
    ST_WAIT  = 3'b111
  } chg_state_t;

  typedef struct packed {
    logic term_cmp;
    logic bat_above_short;
    logic lin_precharge;
    logic die_hot;
    logic charge_loop_inactive;
    logic input_limit_inactive;
    logic input_supply_valid;
    logic constant_voltage;
  } chg_mon_t;

  typedef struct packed {
    chg_mon_t   mon;
    logic [1:0] chg_state;
    logic [2:0] chg_fault;
    logic       boost_active;
    logic       bst_ovp;
    logic       bst_hot;
    logic       bst_ss_fail;
    logic       bst_ilim;
    logic       weak_src;
    logic       dis_pin;
  } chg_ana_t;

  typedef struct packed {
    logic [1:0] input_current_limit;
    logic       termination_enable;
    logic       charger_disable;
    logic       high_impedance_request;
    logic       boost_request;
    logic [5:0] float_voltage;
    logic       boost_pin_polarity;
    logic       boost_pin_enable;
    logic [2:0] charge_current_setting;
    logic [2:0] termination_setting;
    logic [2:0] weak_source_regulation_voltage;
    logic [1:0] recharge_drop;
  } chg_ctl_t;

endpackage : chg_pkg

// [hw/chg_sync.sv]
// Two-stage synchroniser for signals from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module chg_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output var  logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= RST_VAL;
      q_o    <= RST_VAL;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule : chg_sync
`default_nettype wire

// [hw/chg_i2c_slave.sv]
// Serial slave and register map of the charger
`timescale 1ns/1ps
`default_nettype none
module chg_i2c_slave #(
  parameter int         ILIM_CYC = chg_pkg::ILIM_CYC,
  // Identification value is arbitrary
  parameter logic [7:0] CHIP_ID  = 8'h5A
) (
  // Clock and reset
  input  wire logic              CLK_SYS_I,
  input  wire logic              RST_I,
  // Serial link
  input  wire logic              SCL_I,
  input  wire logic              SDA_I,
  output var  logic              SDA_O,
  output var  logic              SDA_OE_O,
  // Charger and boost status
  input  wire chg_pkg::chg_ana_t ANA_I,
  // Control outputs
  output var  chg_pkg::chg_ctl_t CTL_O,
  output var  logic              STAT_LOW_O,
  output var  logic              HS_MODE_O
);

  // ==========================================================
  // Input synchronisation
  // ==========================================================
  logic [1:0]        pin_s;
  chg_pkg::chg_ana_t ana_s;
  logic              scl_p_q;
  logic              sda_p_q;
  logic              scl;
  logic              sda;
  logic              scl_rise;
  logic              scl_fall;
  logic              start_det;
  logic              stop_det;

  // clock is input only
  // Idle bus level, no false edge after reset
  chg_sync #(.W(2), .RST_VAL(2'h3)) u_pin_sync (
    .clk_i (CLK_SYS_I),
    .rst_i (RST_I),
    .d_i   ({SCL_I, SDA_I}),
    .q_o   (pin_s)
  );

  chg_sync #(.W($bits(chg_pkg::chg_ana_t))) u_ana_sync (
    .clk_i (CLK_SYS_I),
    .rst_i (RST_I),
    .d_i   (ANA_I),
    .q_o   (ana_s)
  );

  assign scl = pin_s[1];
  assign sda = pin_s[0];

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl;
      sda_p_q <= sda;
    end
  end

  assign scl_rise  = scl & ~scl_p_q;
  assign scl_fall  = ~scl & scl_p_q;
  assign start_det = scl & scl_p_q & sda_p_q & ~sda;
  assign stop_det  = scl & scl_p_q & ~sda_p_q & sda;

  // ==========================================================
  // Link state machine
  // ==========================================================
  chg_pkg::chg_state_t st_q;
  chg_pkg::chg_state_t nxt_q;
  logic [3:0]          cnt_q;
  logic [7:0]          sh_q;
  logic [7:0]          ptr_q;
  logic                oe_q;
  logic                mack_q;
  logic                hs_arm_q;
  logic                hs_q;
  logic                wr_q;
  logic [7:0]          wadr_q;
  logic [7:0]          wdat_q;
  logic [7:0]          rd_data;

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      st_q     <= chg_pkg::ST_IDLE;
      nxt_q    <= chg_pkg::ST_IDLE;
      cnt_q    <= 4'h0;
      sh_q     <= 8'h00;
      ptr_q    <= 8'h00;
      oe_q     <= 1'b0;
      mack_q   <= 1'b0;
      hs_arm_q <= 1'b0;
      hs_q     <= 1'b0;
      wr_q     <= 1'b0;
      wadr_q   <= 8'h00;
      wdat_q   <= 8'h00;
    end else begin
      wr_q <= 1'b0;
      if (stop_det) begin
        st_q     <= chg_pkg::ST_IDLE;
        oe_q     <= 1'b0;
        hs_arm_q <= 1'b0;
        hs_q     <= 1'b0;
      end else if (start_det) begin
        if (hs_arm_q) begin
          hs_q <= 1'b1;
        end
        hs_arm_q <= 1'b0;
        st_q     <= chg_pkg::ST_DEV;
        cnt_q    <= 4'h0;
        oe_q     <= 1'b0;
      end else begin
        case (st_q)
          chg_pkg::ST_DEV, chg_pkg::ST_REG, chg_pkg::ST_WR: begin
            if (scl_rise) begin
              sh_q  <= {sh_q[6:0], sda};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == chg_pkg::BYTE_BITS) begin
              cnt_q <= 4'h0;
              if (st_q == chg_pkg::ST_DEV) begin
                if (sh_q[7:1] == chg_pkg::DEV_ADDR) begin
                  oe_q  <= 1'b1;
                  st_q  <= chg_pkg::ST_ACK;
                  nxt_q <= sh_q[0] ? chg_pkg::ST_TX : chg_pkg::ST_REG;
                end else if (sh_q[7:3] == chg_pkg::HS_CODE) begin
                  hs_arm_q <= 1'b1;
                  st_q     <= chg_pkg::ST_WAIT;
                end else begin
                  st_q <= chg_pkg::ST_WAIT;
                end
              end else if (st_q == chg_pkg::ST_REG) begin
                ptr_q <= sh_q;
                oe_q  <= 1'b1;
                st_q  <= chg_pkg::ST_ACK;
                nxt_q <= chg_pkg::ST_WR;
              end else begin
                wr_q   <= 1'b1;
                wadr_q <= ptr_q;
                wdat_q <= sh_q;
                ptr_q  <= ptr_q + 8'h01;
                oe_q   <= 1'b1;
                st_q   <= chg_pkg::ST_ACK;
                nxt_q  <= chg_pkg::ST_WR;
              end
            end
          end
          chg_pkg::ST_ACK: begin
            if (scl_fall) begin
              st_q <= nxt_q;
              if (nxt_q == chg_pkg::ST_TX) begin
                sh_q  <= rd_data;
                oe_q  <= ~rd_data[7];
                cnt_q <= 4'h1;
                ptr_q <= ptr_q + 8'h01;
              end else begin
                oe_q  <= 1'b0;
                cnt_q <= 4'h0;
              end
            end
          end
          chg_pkg::ST_TX: begin
            if (scl_fall) begin
              if (cnt_q == chg_pkg::BYTE_BITS) begin
                oe_q <= 1'b0;
                st_q <= chg_pkg::ST_TXACK;
              end else begin
                oe_q  <= ~sh_q[6];
                sh_q  <= {sh_q[6:0], 1'b0};
                cnt_q <= cnt_q + 4'h1;
              end
            end
          end
          chg_pkg::ST_TXACK: begin
            if (scl_rise) begin
              mack_q <= ~sda;
            end else if (scl_fall) begin
              if (mack_q) begin
                sh_q  <= rd_data;
                oe_q  <= ~rd_data[7];
                cnt_q <= 4'h1;
                ptr_q <= ptr_q + 8'h01;
                st_q  <= chg_pkg::ST_TX;
              end else begin
                st_q <= chg_pkg::ST_WAIT;
              end
            end
          end
          default: begin
            oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Boost fault detection
  // ==========================================================
  localparam int ICW = $clog2(ILIM_CYC + 1);
  logic [ICW-1:0] ilim_cnt_q;
  logic           ilim_flt_q;
  logic [2:0]     bst_code;
  logic [2:0]     fault_q;
  logic           bst_flt_p_q;
  logic           bst_flt_new;

  // current limit longer than limit time
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      ilim_cnt_q <= '0;
      ilim_flt_q <= 1'b0;
    end else if (!ana_s.boost_active) begin
      ilim_cnt_q <= '0;
      ilim_flt_q <= 1'b0;
    end else if (!ana_s.bst_ilim) begin
      ilim_cnt_q <= '0;
    end else if (ilim_cnt_q == ICW'(ILIM_CYC)) begin
      ilim_flt_q <= 1'b1;
    end else begin
      ilim_cnt_q <= ilim_cnt_q + ICW'(1);
    end
  end

  always_comb begin
    if (ana_s.bst_ovp) begin
      bst_code = chg_pkg::FLT_OVP;
    end else if (ana_s.bst_hot) begin
      bst_code = chg_pkg::FLT_HOT;
    end else if (ana_s.bst_ss_fail || ilim_flt_q) begin
      bst_code = chg_pkg::FLT_BOOST;
    end else begin
      bst_code = chg_pkg::FLT_NONE;
    end
  end

  assign bst_flt_new = ana_s.boost_active && (bst_code != chg_pkg::FLT_NONE)
                       && !bst_flt_p_q;

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      fault_q     <= chg_pkg::FLT_NONE;
      bst_flt_p_q <= 1'b0;
    end else begin
      fault_q     <= ana_s.boost_active ? bst_code : ana_s.chg_fault;
      bst_flt_p_q <= ana_s.boost_active && (bst_code != chg_pkg::FLT_NONE);
    end
  end

  // ==========================================================
  // Writable registers
  // ==========================================================
  logic [1:0] status_rw_q;
  logic [7:0] charge_q;
  logic [7:0] float_q;
  logic [7:0] curr_q;
  logic [2:0] weak_hi_q;
  logic [2:0] weak_vsp_q;
  logic [7:0] rch_q;

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      status_rw_q <= chg_pkg::RST_STATUS_RW;
      charge_q    <= chg_pkg::RST_CHARGE;
      float_q     <= chg_pkg::RST_FLOAT;
      curr_q      <= chg_pkg::RST_CURR;
      weak_hi_q   <= chg_pkg::RST_WEAK_HI;
      weak_vsp_q  <= chg_pkg::RST_WEAK_VSP;
      rch_q       <= chg_pkg::RST_RCH;
    end else begin
      if (wr_q) begin
        case (wadr_q)
          chg_pkg::ADR_STATUS: status_rw_q <= wdat_q[7:6];
          chg_pkg::ADR_CHARGE: charge_q <= wdat_q;
          chg_pkg::ADR_FLOAT:  float_q <= wdat_q;
          chg_pkg::ADR_CURR:   curr_q <= wdat_q;
          chg_pkg::ADR_WEAK: begin
            weak_hi_q  <= wdat_q[7:5];
            weak_vsp_q <= wdat_q[2:0];
          end
          chg_pkg::ADR_RCH:    rch_q <= wdat_q;
          default: begin
          end
        endcase
      end
      // Boost fault drops the boost request
      if (bst_flt_new) begin
        charge_q[chg_pkg::BIT_BST_REQ] <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Read data
  // ==========================================================
  always_comb begin
    case (ptr_q)
      chg_pkg::ADR_STATUS: rd_data = {status_rw_q, ana_s.chg_state,
                                      ana_s.boost_active, fault_q};
      chg_pkg::ADR_CHARGE: rd_data = charge_q;
      chg_pkg::ADR_FLOAT:  rd_data = float_q;
      chg_pkg::ADR_ID:     rd_data = CHIP_ID;
      chg_pkg::ADR_CURR:   rd_data = curr_q;
      chg_pkg::ADR_WEAK:   rd_data = {weak_hi_q, ana_s.weak_src,
                                      ana_s.dis_pin, weak_vsp_q};
      chg_pkg::ADR_RCH:    rd_data = rch_q;
      chg_pkg::ADR_MON:    rd_data = ana_s.mon;
      default:             rd_data = chg_pkg::RD_UNMAPPED;
    endcase
  end

  // ==========================================================
  // Control outputs
  // ==========================================================
  chg_pkg::chg_ctl_t ctl_q;
  logic              stat_low_q;

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      ctl_q      <= '0;
      stat_low_q <= 1'b0;
    end else begin
      ctl_q.input_current_limit <= charge_q[7:6];
      ctl_q.termination_enable  <= charge_q[chg_pkg::BIT_TERM_EN];
      ctl_q.charger_disable     <= charge_q[chg_pkg::BIT_CHG_DIS];
      ctl_q.high_impedance_request <= charge_q[chg_pkg::BIT_HIZ];
      ctl_q.boost_request <= charge_q[chg_pkg::BIT_BST_REQ]
                             & ~charge_q[chg_pkg::BIT_HIZ];
      ctl_q.float_voltage <= float_q[7:2];
      ctl_q.boost_pin_polarity <= float_q[chg_pkg::BIT_PIN_POL];
      ctl_q.boost_pin_enable   <= float_q[chg_pkg::BIT_PIN_EN];
      ctl_q.charge_current_setting <= curr_q[6:4];
      ctl_q.termination_setting <= curr_q[2:0];
      ctl_q.weak_source_regulation_voltage <= weak_vsp_q;
      ctl_q.recharge_drop <= rch_q[1:0];
      stat_low_q <= status_rw_q[chg_pkg::BIT_STAT_EN - 6]
                    & (ana_s.chg_state == chg_pkg::CS_CHARGING);
    end
  end

  // Open drain: level always low, enable pulls
  assign SDA_O      = 1'b0;
  assign SDA_OE_O   = oe_q;
  assign CTL_O      = ctl_q;
  assign STAT_LOW_O = stat_low_q;
  assign HS_MODE_O  = hs_q;

endmodule : chg_i2c_slave
`default_nettype wire

// [bench/chg_master.sv]
// Serial bus master model for the charger slave
`timescale 1ns/1ps
`default_nettype none
module chg_master (
  // Serial link
  output var  logic scl_o,
  output var  logic sda_pull_o,
  input  wire logic sda_i
);
  // Clock period 48 ns, high outside frames; edges on whole ns, off rising system edges
  logic busy;
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
    busy = 1'b0;
  end
  task automatic start();
    if (busy) begin
      scl_o = 1'b0;
      #12 sda_pull_o = 1'b0;
      #12 scl_o = 1'b1;
      #24;
    end else begin
      #0.5;
    end
    sda_pull_o = 1'b1;
    #24 busy = 1'b1;
  endtask : start
  task automatic stop();
    scl_o = 1'b0;
    #12 sda_pull_o = 1'b1;
    #12 scl_o = 1'b1;
    #24 sda_pull_o = 1'b0;
    #24.5 busy = 1'b0;
  endtask : stop
  task automatic bit_x(input logic b, output logic s);
    scl_o = 1'b0;
    #12 sda_pull_o = ~b;
    #12 scl_o = 1'b1;
    #12 s = sda_i;
    #12;
  endtask : bit_x
  task automatic wr(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(d[i], s);
    bit_x(1'b1, s);
    ack = ~s;
  endtask : wr
  task automatic rd(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, s);
      d[i] = s;
    end
    bit_x(~ack, s);
  endtask : rd
endmodule : chg_master
`default_nettype wire

// [bench/chg_i2c_chk.sv]
// Port-level assertions of the charger serial slave
`timescale 1ns/1ps
`default_nettype none
module chg_i2c_chk #(
  parameter int         ILIM_CYC = chg_pkg::ILIM_CYC,
  parameter logic [7:0] CHIP_ID  = 8'h5A
) (
  // Clock and reset
  input wire logic              CLK_SYS_I,
  input wire logic              RST_I,
  // Serial link
  input wire logic              SCL_I,
  input wire logic              SDA_I,
  input wire logic              SDA_O,
  input wire logic              SDA_OE_O,
  // Status and control
  input wire chg_pkg::chg_ana_t ANA_I,
  input wire chg_pkg::chg_ctl_t CTL_O,
  input wire logic              STAT_LOW_O,
  input wire logic              HS_MODE_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  int ilim_cnt_q;
  // Length of current limiting while boosting
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I || !(ANA_I.boost_active && ANA_I.bst_ilim)) ilim_cnt_q <= 0;
    else if (ilim_cnt_q < ILIM_CYC + 12) ilim_cnt_q <= ilim_cnt_q + 1;
  end
  sequence s_stop;
    SCL_I && $rose(SDA_I);
  endsequence
  sequence s_ovp_boost;
    ANA_I.boost_active && $rose(ANA_I.bst_ovp);
  endsequence
  sequence s_idle4;
    (ANA_I.chg_state != chg_pkg::CS_CHARGING) [*4];
  endsequence
  a_sda_pull_only: assert property (SDA_O == 1'b0)
    else $error("data output not pulled low");
  a_oe_clk_low: assert property ($changed(SDA_OE_O) |-> !SCL_I)
    else $error("data enable moved with clock high");
  a_hs_on_start: assert property ($rose(HS_MODE_O) |-> SCL_I && !SDA_I)
    else $error("high speed entered without start");
  a_hs_off_stop: assert property (s_stop |-> ##8 !HS_MODE_O)
    else $error("high speed kept after stop");
  a_stat_idle: assert property (s_idle4 |-> !STAT_LOW_O)
    else $error("status pin low while not charging");
  a_ovp_drop_req: assert property (s_ovp_boost |-> ##[1:8] !CTL_O.boost_request)
    else $error("boost request kept after fault");
  a_ilim_drop_req: assert property (ilim_cnt_q == ILIM_CYC + 12 |-> !CTL_O.boost_request)
    else $error("boost request kept after long limit");
  a_hiz_wins: assert property (CTL_O.high_impedance_request |-> !CTL_O.boost_request)
    else $error("boost request beside high impedance");
  a_ctl_reset: assert property ($fell(RST_I) |-> ##3 (CTL_O.input_current_limit == 2'h1
    && !CTL_O.termination_enable && CTL_O.float_voltage == 6'h02
    && CTL_O.boost_pin_polarity && CTL_O.recharge_drop == 2'h1))
    else $error("control fields not at reset values");
endmodule : chg_i2c_chk
bind chg_i2c_slave chg_i2c_chk #(.ILIM_CYC(ILIM_CYC), .CHIP_ID(CHIP_ID)) chg_i2c_chk_i (
  .CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O),
  .SDA_OE_O(SDA_OE_O), .ANA_I(ANA_I), .CTL_O(CTL_O), .STAT_LOW_O(STAT_LOW_O),
  .HS_MODE_O(HS_MODE_O)
);
`default_nettype wire

// [bench/test_chg_i2c_slave.sv]
// Self-checking testbench of the charger serial slave
`timescale 1ns/1ps
`default_nettype none
module test_chg_i2c_slave;
  localparam int         ILIM_T = 20;
  localparam int         LIMIT  = 40000;
  // Identification value is arbitrary
  localparam logic [7:0] ID_VAL = 8'hC3;
  logic clk_sys, rst, scl, m_pull, sda_drv, sda_oe, stat_low, hs_mode;
  wire logic sda;
  chg_pkg::chg_ana_t ana;
  chg_pkg::chg_ctl_t ctl;
  int error_cnt, checked, cyc;
  logic [7:0] d;
  logic [2:0] a;
  assign sda = ~(sda_oe | m_pull);
  chg_i2c_slave #(.ILIM_CYC(ILIM_T), .CHIP_ID(ID_VAL)) chg_i2c_slave_i (
    .CLK_SYS_I(clk_sys), .RST_I(rst), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_drv),
    .SDA_OE_O(sda_oe), .ANA_I(ana), .CTL_O(ctl), .STAT_LOW_O(stat_low), .HS_MODE_O(hs_mode));
  chg_master chg_master_i (.scl_o(scl), .sda_pull_o(m_pull), .sda_i(sda));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      error_cnt++;
      results();
    end
  end
  task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", w, e, g);
      error_cnt++;
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  task automatic wreg(input logic [7:0] r, input logic [7:0] v);
    chg_master_i.start();
    chg_master_i.wr(8'hD4, a[0]);
    chg_master_i.wr(r, a[1]);
    chg_master_i.wr(v, a[2]);
    chg_master_i.stop();
    chk("write acks", 8'h07, 8'(a));
  endtask : wreg
  task automatic rreg(input logic [7:0] r);
    chg_master_i.start();
    chg_master_i.wr(8'hD4, a[0]);
    chg_master_i.wr(r, a[1]);
    chg_master_i.start();
    chg_master_i.wr(8'hD5, a[2]);
    chg_master_i.rd(1'b0, d);
    chg_master_i.stop();
    chk("read acks", 8'h07, 8'(a));
  endtask : rreg
  task automatic t_regs();
    logic [7:0] r [6] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h07, 8'h06};
    logic [7:0] e [6] = '{8'h70, 8'h0A, ID_VAL, 8'h74, 8'h01, 8'h00};
    for (int i = 0; i < 6; i++) begin
      rreg(r[i]);
      chk("reset value", e[i], d);
    end
    wreg(8'h03, 8'h00);
    rreg(8'h03);
    chk("id kept", ID_VAL, d);
    wreg(8'h05, 8'hFF);
    rreg(8'h05);
    chk("weak source", 8'hF7, d);
    @(posedge clk_sys);
    ana.weak_src <= 1'b0;
    ana.dis_pin <= 1'b1;
    tick(4);
    rreg(8'h05);
    chk("weak live", 8'hEF, d);
    chk("regulation", 8'h07, 8'(ctl.weak_source_regulation_voltage));
    $display("test registers done");
  endtask : t_regs
  task automatic t_monitor();
    logic [7:0] v [2] = '{8'hA5, 8'h5A};
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys);
      ana.mon <= v[i];
      tick(4);
      wreg(8'h10, ~v[i]);
      rreg(8'h10);
      chk("monitor", v[i], d);
    end
    $display("test monitor done");
  endtask : t_monitor
  task automatic t_fields();
    logic [2:0] k;
    logic [7:0] s;
    for (int i = 0; i < 8; i++) begin
      k = 3'(i);
      wreg(8'h04, {1'b0, k, 1'b0, ~k});
      s = {2'h0, ctl.charge_current_setting, ctl.termination_setting};
      chk("current codes", {2'h0, k, ~k}, s);
      if (i < 4) begin
        wreg(8'h01, {k[1:0], 2'h3, k[0], k[1], 2'h0});
        s = {ctl.input_current_limit, ctl.termination_enable, ctl.charger_disable, 4'h0};
        chk("charge control", {k[1:0], k[0], k[1], 4'h0}, s);
        wreg(8'h07, {6'h00, k[1:0]});
        chk("recharge", {6'h00, k[1:0]}, 8'(ctl.recharge_drop));
      end
      if (i < 2) begin
        wreg(8'h02, i ? 8'h56 : 8'hA9);
        s = {ctl.float_voltage, ctl.boost_pin_polarity, ctl.boost_pin_enable};
        chk("float and pin", i ? 8'h56 : 8'hA9, s);
      end
    end
    $display("test fields done");
  endtask : t_fields
  task automatic t_link();
    chg_master_i.start();
    chg_master_i.wr(8'hD6, a[0]);
    chg_master_i.stop();
    chk("foreign ack", 8'h00, 8'(a[0]));
    chg_master_i.start();
    chg_master_i.wr(8'h0B, a[0]);
    chk("hs code ack", 8'h00, 8'(a[0]));
    chg_master_i.start();
    chk("hs entered", 8'h01, 8'(hs_mode));
    rreg(8'h07);
    chk("hs read", 8'h03, d);
    tick(8);
    chk("hs left", 8'h00, 8'(hs_mode));
    $display("test link done");
  endtask : t_link
  task automatic t_boost();
    logic [2:0] c [3] = '{3'h1, 3'h5, 3'h2};
    @(posedge clk_sys);
    ana.boost_active <= 1'b1;
    ana.chg_fault <= 3'h4;
    wreg(8'h01, 8'h71);
    chk("boost request", 8'h01, 8'(ctl.boost_request));
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      ana.bst_ovp <= (i == 0);
      ana.bst_hot <= (i == 1);
      ana.bst_ss_fail <= (i == 2);
      tick(4);
      rreg(8'h00);
      chk("boost fault", {5'h09, c[i]}, d);
      if (i == 0) chk("fault drop", 8'h00, 8'(ctl.boost_request));
    end
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys);
      ana.bst_ss_fail <= 1'b0;
      wreg(8'h01, 8'h71);
      @(posedge clk_sys);
      ana.bst_ilim <= 1'b1;
      tick(i ? ILIM_T + 14 : ILIM_T / 2);
      ana.bst_ilim <= 1'b0;
      rreg(8'h00);
      chk("limit fault", i ? 8'h4A : 8'h48, d);
      chk("limit request", 8'(1 - i), 8'(ctl.boost_request));
    end
    wreg(8'h01, 8'h73);
    chk("hiz wins", 8'h00, 8'(ctl.boost_request));
    @(posedge clk_sys);
    ana.boost_active <= 1'b0;
    tick(4);
    rreg(8'h00);
    chk("charge status", 8'h44, d);
    $display("test boost done");
  endtask : t_boost
  task automatic t_stat();
    wreg(8'h00, 8'hFF);
    for (int s = 0; s < 4; s++) begin
      @(posedge clk_sys);
      ana.chg_state <= 2'(s);
      tick(4);
      chk("status pin", 8'(s == 1), 8'(stat_low));
      rreg(8'h00);
      chk("status reg", {2'h3, 2'(s), 4'h4}, d);
    end
    @(posedge clk_sys);
    ana.chg_state <= 2'h1;
    wreg(8'h00, 8'h00);
    chk("pin gated", 8'h00, 8'(stat_low));
    $display("test status done");
  endtask : t_stat
  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results
  initial begin
    rst = 1'b1;
    ana = '0;
    ana.weak_src = 1'b1;
    error_cnt = 0;
    checked = 0;
    cyc = 0;
    tick(12);
    rst <= 1'b0;
    tick(4);
    t_regs();
    t_monitor();
    t_fields();
    t_link();
    t_boost();
    t_stat();
    results();
  end
endmodule : test_chg_i2c_slave
`default_nettype wire
